//--- inc/safety_status_pkg.sv
// package: field layout, codes and timing constants of the status report
package safety_status_pkg;
    // main status word bit positions
    localparam int unsigned BIT_NORMAL = 0;
    localparam int unsigned BIT_SELF_TEST = 1;
    localparam int unsigned BIT_TORQUE_OFF = 2;
    localparam int unsigned BIT_STOP_A = 3;
    localparam int unsigned BIT_STOP_B = 4;
    localparam int unsigned BIT_SPEED_A = 5;
    localparam int unsigned BIT_SPEED_B = 6;
    localparam int unsigned BIT_INT_FAIL = 11;
    localparam int unsigned BIT_RESET_REQ = 12;
    localparam int unsigned BIT_PEND_FAILSAFE = 13;
    localparam int unsigned BIT_EXT_FAIL = 14;
    localparam int unsigned BIT_SF_PENDING = 15;
    localparam int unsigned BIT_EVENT_LO = 16;
    localparam int unsigned BIT_WARN_LO = 20;
    localparam int unsigned BIT_ERR_LO = 24;
    // second status word bit positions
    localparam int unsigned BIT_IN1_LO = 0;
    localparam int unsigned BIT_IN2_LO = 2;
    localparam int unsigned BIT_BLANK = 4;
    // safe input codes; 2'b11 is held reserved
    localparam logic [1:0] INPUT_INACTIVE = 2'h0;
    localparam logic [1:0] INPUT_ACTIVE = 2'h1;
    localparam logic [1:0] INPUT_PENDING = 2'h2;
    // reset values
    localparam logic [31:0] MAIN_STATUS_RST = 32'h0000_0002;
    localparam logic [31:0] INPUT_STATUS_RST = 32'h0000_0000;
    // led flash half period
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam logic [24:0] FLASH_LAST = 25'(FLASH_HALF_CYC - 1);

    // led colour and mode
    typedef enum logic [2:0] {
        LED_OFF = 3'b000,
        LED_GREEN_FLASH = 3'b001,
        LED_GREEN_STEADY = 3'b010,
        LED_YELLOW_FLASH = 3'b011,
        LED_RED_FLASH = 3'b100,
        LED_RED_STEADY = 3'b101
    } led_mode_t;

    // fault state of the option
    typedef enum logic [1:0] {
        FLT_SELF_TEST = 2'b00,
        FLT_RUN = 2'b01,
        FLT_ALARM = 2'b10,
        FLT_FATAL = 2'b11
    } fault_state_t;

    // active safe functions
    typedef struct packed {
        logic limited_speed_b;
        logic limited_speed_a;
        logic stop_ramp_b;
        logic stop_ramp_a;
        logic torque_off;
    } safe_func_t;

    // one-cycle event pulses, bit order as in the status word
    typedef struct packed {
        logic custom_requested;
        logic custom_aborted;
        logic custom_confirmed;
        logic general_reset;
    } events_t;

    // warnings, bit order as in the status word
    typedef struct packed {
        logic in2_offline;
        logic in1_offline;
        logic self_test;
        logic speed_suspend;
    } warnings_t;

    // led drive lines
    typedef struct packed {
        logic red;
        logic yellow;
        logic green;
    } led_t;
endpackage : safety_status_pkg

//--- logic/safety_option_status_report.sv
// status report logic of the safety option card
`timescale 1ns/1ps
module safety_option_status_report (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_self_test_done,
    input wire logic i_self_test_warn,
    input wire safety_status_pkg::safe_func_t i_func_active,
    input wire safety_status_pkg::safe_func_t i_func_pending,
    input wire logic i_failsafe_pending,
    input wire logic i_reset_required,
    input wire logic i_int_fail_set,
    input wire logic i_ext_fail_set,
    input wire logic [7:0] i_error_code,
    input wire logic i_fatal_error,
    input wire logic i_restart,
    input wire logic i_fault_reset,
    input wire safety_status_pkg::events_t i_events,
    input wire logic i_speed_suspend,
    input wire logic i_in1_offline_warn,
    input wire logic i_in2_offline_warn,
    input wire logic [1:0] i_safe_input_one,
    input wire logic [1:0] i_safe_input_two,
    input wire logic i_blank_config,
    input wire logic i_validated,
    input wire logic i_output_request,
    output logic [31:0] o_main_status,
    output logic [31:0] o_input_status,
    output logic o_safe_output,
    output logic o_cyclic_run,
    output safety_status_pkg::led_t o_led
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // reserved code 11 is not a legal code, fold it to pending
    function automatic logic [1:0] input_code(input logic [1:0] raw);
        logic [1:0] code;
        code = raw;
        if (raw == 2'h3) begin
            code = safety_status_pkg::INPUT_PENDING;
        end
        return code;
    endfunction : input_code

    // led lines for a colour and mode, flashing gated by the blink phase
    function automatic safety_status_pkg::led_t led_drive(
        input safety_status_pkg::led_mode_t mode,
        input logic phase
    );
        safety_status_pkg::led_t l;
        l = '0;
        case (mode)
            safety_status_pkg::LED_GREEN_FLASH: l.green = phase;
            safety_status_pkg::LED_GREEN_STEADY: l.green = 1'b1;
            safety_status_pkg::LED_YELLOW_FLASH: l.yellow = phase;
            safety_status_pkg::LED_RED_FLASH: l.red = phase;
            safety_status_pkg::LED_RED_STEADY: l.red = 1'b1;
            default: l = '0;
        endcase
        return l;
    endfunction : led_drive

    ////////////////////////////////////////////////////////////////////////
    // fault state and failure flags

    safety_status_pkg::fault_state_t state_ff;
    safety_status_pkg::fault_state_t nxt_state;
    logic int_fail_ff;
    logic nxt_int_fail;
    logic ext_fail_ff;
    logic nxt_ext_fail;
    logic [7:0] err_code_ff;
    logic [7:0] nxt_err_code;
    safety_status_pkg::safe_func_t last_func_ff;
    safety_status_pkg::safe_func_t nxt_last_func;
    safety_status_pkg::safe_func_t shown_func;

    // fatal wins over alarm; a new failure wins over a same-cycle reset
    always_comb begin
        nxt_state = state_ff;
        nxt_int_fail = int_fail_ff;
        nxt_ext_fail = ext_fail_ff;
        nxt_err_code = err_code_ff;
        nxt_last_func = last_func_ff;
        if (state_ff == safety_status_pkg::FLT_FATAL) begin
            // frozen until a restart; only restart leaves this state
            if (i_restart) begin
                nxt_state = safety_status_pkg::FLT_SELF_TEST;
                nxt_int_fail = 1'b0;
                nxt_ext_fail = 1'b0;
                nxt_err_code = 8'h00;
                nxt_last_func = '0;
            end
        end else if (i_fatal_error) begin
            nxt_state = safety_status_pkg::FLT_FATAL;
            nxt_err_code = i_error_code;
            // keep the set shown at entry so the frozen bits do not jump
            nxt_last_func = i_func_active;
        end else if (i_restart) begin
            nxt_state = safety_status_pkg::FLT_SELF_TEST;
            nxt_int_fail = 1'b0;
            nxt_ext_fail = 1'b0;
            nxt_err_code = 8'h00;
            nxt_last_func = '0;
        end else begin
            nxt_last_func = i_func_active;
            if (i_fault_reset) begin
                nxt_ext_fail = 1'b0;
            end
            if (i_ext_fail_set) begin
                nxt_ext_fail = 1'b1;
            end
            if (i_int_fail_set) begin
                nxt_int_fail = 1'b1;
            end
            if (i_int_fail_set || i_ext_fail_set) begin
                nxt_err_code = i_error_code;
            end else if (i_fault_reset && !int_fail_ff) begin
                nxt_err_code = 8'h00;
            end
            case (state_ff)
                safety_status_pkg::FLT_SELF_TEST: begin
                    if (i_self_test_done) begin
                        nxt_state = safety_status_pkg::FLT_RUN;
                    end
                end
                safety_status_pkg::FLT_RUN: begin
                    if (nxt_int_fail || nxt_ext_fail) begin
                        nxt_state = safety_status_pkg::FLT_ALARM;
                    end
                end
                safety_status_pkg::FLT_ALARM: begin
                    if (!nxt_int_fail && !nxt_ext_fail) begin
                        nxt_state = safety_status_pkg::FLT_RUN;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    // fault state registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= safety_status_pkg::FLT_SELF_TEST;
            int_fail_ff <= 1'b0;
            ext_fail_ff <= 1'b0;
            err_code_ff <= 8'h00;
            last_func_ff <= '0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            int_fail_ff <= nxt_int_fail;
            ext_fail_ff <= nxt_ext_fail;
            err_code_ff <= nxt_err_code;
            last_func_ff <= nxt_last_func;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status words

    logic [31:0] main_ff;
    logic [31:0] nxt_main;
    logic [31:0] input_ff;
    logic [31:0] nxt_input;
    logic any_warning;
    logic any_pending;
    logic fatal_now;

    // a fatal error freezes the function bits at the last active set
    assign fatal_now = (state_ff == safety_status_pkg::FLT_FATAL);
    assign shown_func = fatal_now ? last_func_ff : i_func_active;
    assign any_warning = i_speed_suspend | i_self_test_warn
                       | i_in1_offline_warn | i_in2_offline_warn;
    assign any_pending = (|i_func_pending) | i_failsafe_pending;

    // both words rebuilt every enabled cycle from live inputs and the fault state registers
    always_comb begin
        nxt_main = 32'h0000_0000;
        nxt_main[safety_status_pkg::BIT_NORMAL] =
            (state_ff == safety_status_pkg::FLT_RUN) && !(|shown_func)
            && !any_pending && !any_warning;
        nxt_main[safety_status_pkg::BIT_SELF_TEST] =
            (state_ff == safety_status_pkg::FLT_SELF_TEST);
        // only active functions land here, pending ones never do
        nxt_main[safety_status_pkg::BIT_TORQUE_OFF] =
            shown_func.torque_off;
        nxt_main[safety_status_pkg::BIT_STOP_A] = shown_func.stop_ramp_a;
        nxt_main[safety_status_pkg::BIT_STOP_B] = shown_func.stop_ramp_b;
        nxt_main[safety_status_pkg::BIT_SPEED_A] =
            shown_func.limited_speed_a;
        nxt_main[safety_status_pkg::BIT_SPEED_B] =
            shown_func.limited_speed_b;
        nxt_main[safety_status_pkg::BIT_INT_FAIL] = int_fail_ff;
        nxt_main[safety_status_pkg::BIT_EXT_FAIL] = ext_fail_ff;
        nxt_main[safety_status_pkg::BIT_RESET_REQ] =
            i_reset_required | ext_fail_ff;
        nxt_main[safety_status_pkg::BIT_PEND_FAILSAFE] =
            i_failsafe_pending;
        nxt_main[safety_status_pkg::BIT_SF_PENDING] =
            |i_func_pending;
        nxt_main[safety_status_pkg::BIT_EVENT_LO +: 4] = i_events;
        nxt_main[safety_status_pkg::BIT_WARN_LO +: 4] =
            {i_in2_offline_warn, i_in1_offline_warn,
             i_self_test_warn, i_speed_suspend};
        nxt_main[safety_status_pkg::BIT_ERR_LO +: 8] = err_code_ff;
        nxt_input = 32'h0000_0000;
        nxt_input[safety_status_pkg::BIT_IN1_LO +: 2] =
            input_code(i_safe_input_one);
        nxt_input[safety_status_pkg::BIT_IN2_LO +: 2] =
            input_code(i_safe_input_two);
        nxt_input[safety_status_pkg::BIT_BLANK] = i_blank_config;
    end

    // read-only words, refreshed each enabled cycle
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            main_ff <= safety_status_pkg::MAIN_STATUS_RST;
            input_ff <= safety_status_pkg::INPUT_STATUS_RST;
        end else if (i_ce) begin
            main_ff <= nxt_main;
            input_ff <= nxt_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // safe output, cyclic flag and led

    logic out_ff;
    logic nxt_out;
    logic run_ff;
    logic nxt_run;
    logic [24:0] blink_cnt_ff;
    logic [24:0] nxt_blink_cnt;
    logic phase_ff;
    logic nxt_phase;
    safety_status_pkg::led_t led_ff;
    safety_status_pkg::led_t nxt_led;
    safety_status_pkg::led_mode_t mode;

    // led mode by priority: fatal, alarm, unvalidated, activity, ok
    always_comb begin
        if (nxt_state == safety_status_pkg::FLT_FATAL) begin
            mode = safety_status_pkg::LED_RED_STEADY;
        end else if (nxt_state == safety_status_pkg::FLT_ALARM) begin
            mode = safety_status_pkg::LED_RED_FLASH;
        end else if (!i_validated) begin
            mode = safety_status_pkg::LED_YELLOW_FLASH;
        end else if ((|i_func_active) || i_output_request) begin
            mode = safety_status_pkg::LED_GREEN_STEADY;
        end else begin
            mode = safety_status_pkg::LED_GREEN_FLASH;
        end
    end

    // output only on in run state; a fault raised in run state forces it off
    always_comb begin
        nxt_out = (nxt_state == safety_status_pkg::FLT_RUN)
                  && i_output_request;
        nxt_run = (nxt_state != safety_status_pkg::FLT_FATAL);
        nxt_blink_cnt = blink_cnt_ff + 25'h1;
        nxt_phase = phase_ff;
        if (blink_cnt_ff == safety_status_pkg::FLASH_LAST) begin
            nxt_blink_cnt = 25'h0;
            nxt_phase = !phase_ff;
        end
        nxt_led = led_drive(mode, nxt_phase);
    end

    // output registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_ff <= 1'b0;
            run_ff <= 1'b0;
            blink_cnt_ff <= 25'h0;
            phase_ff <= 1'b0;
            led_ff <= '0;
        end else if (i_ce) begin
            out_ff <= nxt_out;
            run_ff <= nxt_run;
            blink_cnt_ff <= nxt_blink_cnt;
            phase_ff <= nxt_phase;
            led_ff <= nxt_led;
        end
    end

    assign o_main_status = main_ff;
    assign o_input_status = input_ff;
    assign o_safe_output = out_ff;
    assign o_cyclic_run = run_ff;
    assign o_led = led_ff;

endmodule : safety_option_status_report

//--- sim/drive_host_model.sv
// host side model: status word mapping and reset source choice
`timescale 1ns/1ps
module drive_host_model #(
    parameter int RESET_SOURCE = 1
) (
    input wire logic [31:0] i_main_status,
    input wire logic i_drive_reset,
    input wire logic i_safe_reset,
    output logic o_fault_reset,
    output logic [1:0] o_drive_status_word
);
    // only the chosen source reaches the option; the other is dropped
    assign o_fault_reset = (RESET_SOURCE == 0) ? i_drive_reset
                                               : i_safe_reset;
    // bit 1 reset required, bit 0 safe function active
    assign o_drive_status_word = {i_main_status[12],
                                  |i_main_status[6:2]};
endmodule : drive_host_model

//--- sim/safety_option_status_report_assertions.sv
// checker: port-level timing properties of the status report block
`timescale 1ns/1ps
module status_report_checker (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire safety_status_pkg::safe_func_t i_func_active,
    input wire safety_status_pkg::safe_func_t i_func_pending,
    input wire safety_status_pkg::events_t i_events,
    input wire logic i_speed_suspend,
    input wire logic i_self_test_warn,
    input wire logic i_in1_offline_warn,
    input wire logic i_in2_offline_warn,
    input wire logic [1:0] i_safe_input_one,
    input wire logic i_blank_config,
    input wire logic i_output_request,
    input wire logic i_fatal_error,
    input wire logic i_restart,
    input wire logic i_ext_fail_set,
    input wire logic i_fault_reset,
    input wire logic [31:0] o_main_status,
    input wire logic [31:0] o_input_status,
    input wire logic o_safe_output,
    input wire logic o_cyclic_run,
    input wire safety_status_pkg::led_t o_led
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    // enabled cycle without restart, fatal entry or reset strobe
    logic calm;
    assign calm = i_ce && !i_restart && !i_fatal_error && !i_fault_reset;

    ///////////////////////////////////////////////////////////////////
    // level fields follow the inputs of the previous enabled edge
    sequence live;
        calm ##1 o_cyclic_run;
    endsequence
    chk_func_bits: assert property (live |->
        o_main_status[6:2] == $past(i_func_active))
        else $error("function bits do not follow the active set");
    chk_pend_bit: assert property (live |->
        o_main_status[15] == |$past(i_func_pending))
        else $error("pending bit wrong");
    chk_event_bits: assert property (live |->
        o_main_status[19:16] == $past(i_events))
        else $error("event bits wrong");
    chk_warn_bits: assert property (live |->
        o_main_status[20] == $past(i_speed_suspend) &&
        o_main_status[21] == $past(i_self_test_warn) &&
        o_main_status[22] == $past(i_in1_offline_warn) &&
        o_main_status[23] == $past(i_in2_offline_warn))
        else $error("warning bits wrong");
    // the reserved code 11 is folded onto pending
    chk_input_code: assert property (live |->
        o_input_status[1:0] == (($past(i_safe_input_one) == 2'h3) ?
        2'h2 : $past(i_safe_input_one)))
        else $error("input one code wrong");
    chk_blank_bit: assert property (live |->
        o_input_status[4] == $past(i_blank_config))
        else $error("blank bit wrong");
    chk_reserved_bits: assert property (
        o_main_status[10:7] == 4'h0 && o_input_status[31:5] == 27'h0)
        else $error("reserved bits not zero");
    chk_normal_quiet: assert property (o_main_status[0] |->
        o_main_status[6:1] == 6'h00 && !o_main_status[15] &&
        o_main_status[23:20] == 4'h0)
        else $error("normal bit set while something is active");

    ///////////////////////////////////////////////////////////////////
    // output, fault and lamp behaviour
    chk_output_cause: assert property (
        $past(i_ce) && o_safe_output |->
        o_cyclic_run && $past(i_output_request))
        else $error("safe output on without cause");
    chk_fatal_entry: assert property (
        calm == calm && i_ce && i_fatal_error && !i_restart &&
        o_cyclic_run ##1 i_ce && !i_restart |=> !o_cyclic_run &&
        !o_safe_output && o_led == 3'h4 && !o_main_status[0])
        else $error("fatal error not entered");
    chk_fatal_freeze: assert property (
        !o_cyclic_run && o_led == 3'h4 && i_ce && !i_restart &&
        !$past(i_restart) |=> $stable(o_main_status[6:2]))
        else $error("function bits move in fatal state");
    // flag edge then word edge; three calm cycles cover both
    chk_ext_fail: assert property (
        i_ext_fail_set && calm && o_cyclic_run && !o_main_status[1]
        ##1 calm [*3] |-> o_main_status[14] && o_main_status[12] &&
        !o_safe_output && o_cyclic_run)
        else $error("external failure not reported");

    cover property (i_ext_fail_set ##[1:3] o_main_status[14]);
    cover property (!o_cyclic_run && o_led == 3'h4);
    cover property (o_main_status[0] && o_safe_output);
    cover property ($fell(o_main_status[1]));
endmodule : status_report_checker

bind safety_option_status_report status_report_checker chk_i (.*);

//--- sim/safety_option_status_report_tb_top.sv
// testbench: status report block against a behavioural model
`timescale 1ns/1ps
module safety_option_status_report_tb_top;
    logic i_sys_clk, i_rstn, i_ce, i_self_test_done, i_self_test_warn;
    logic i_failsafe_pending, i_reset_required, i_int_fail_set;
    logic i_ext_fail_set, i_fatal_error, i_restart, i_speed_suspend;
    logic i_in1_offline_warn, i_in2_offline_warn, i_blank_config;
    logic i_validated, i_output_request, drive_reset, safe_reset;
    logic i_fault_reset, o_safe_output, o_cyclic_run;
    logic [7:0] i_error_code, err_m;
    logic [1:0] i_safe_input_one, i_safe_input_two, host_word;
    logic [31:0] o_main_status, o_input_status, seed, r;
    safety_status_pkg::safe_func_t i_func_active, i_func_pending;
    safety_status_pkg::events_t i_events;
    safety_status_pkg::led_t o_led;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int st_m, ext_m;

    safety_option_status_report uut (.*);
    drive_host_model #(.RESET_SOURCE(1)) host (.i_main_status(o_main_status),
        .i_drive_reset(drive_reset), .i_safe_reset(safe_reset),
        .o_fault_reset(i_fault_reset), .o_drive_status_word(host_word));

    // 100 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    ///////////////////////////////////////////////////////////////////
    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [1:0] fold(input logic [1:0] c);
        return (c == 2'h3) ? 2'h2 : c;
    endfunction : fold

    // main word model from held inputs and model state
    function automatic logic [31:0] exp_main();
        logic [3:0] wn;
        logic q;
        wn = {i_in2_offline_warn, i_in1_offline_warn, i_self_test_warn,
              i_speed_suspend};
        q = i_func_active == 5'h00 && i_func_pending == 5'h00 &&
            wn == 4'h0 && !i_failsafe_pending;
        return {err_m, wn, i_events, |i_func_pending, ext_m[0],
                i_failsafe_pending, i_reset_required | ext_m[0], 1'b0,
                4'h0, i_func_active, st_m == 0,
                st_m == 1 && ext_m == 0 && q};
    endfunction : exp_main

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : cmp_word

    task automatic cmp_pin(input logic [2:0] got, input logic [2:0] e);
        comparisons++;
        if (got !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : cmp_pin

    task automatic step(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : step

    // random stimulus; and-ing two draws keeps flags sparse
    task automatic drive(input logic [31:0] a, input logic [31:0] s);
        {i_func_active, i_func_pending, i_events, i_failsafe_pending,
         i_reset_required, i_speed_suspend, i_self_test_warn,
         i_in1_offline_warn, i_in2_offline_warn} = a[19:0] & s[19:0];
        {i_safe_input_one, i_safe_input_two, i_blank_config, i_validated,
         i_output_request} = s[31:25];
    endtask : drive

    task automatic check_all();
        logic on;
        on = st_m == 1 && ext_m == 0;
        cmp_word(o_main_status, exp_main());
        cmp_word(o_input_status, {27'h0, i_blank_config,
            fold(i_safe_input_two), fold(i_safe_input_one)});
        cmp_pin(3'(o_safe_output), 3'(on && i_output_request));
        cmp_pin(3'(host_word), 3'({o_main_status[12], |i_func_active}));
        // an unvalidated configuration outranks activity on the lamp
        if (on && i_validated && (|i_func_active || i_output_request))
            cmp_pin(o_led, 3'h1);
        else if (on && i_validated) cmp_pin(o_led & 3'h6, 3'h0);
        else if (on) cmp_pin(o_led & 3'h5, 3'h0);
        else if (st_m == 1) cmp_pin(o_led & 3'h3, 3'h0);
    endtask : check_all

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // hang guard
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    ///////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h5d;
        {st_m, ext_m, err_m, i_error_code} = '0;
        {i_rstn, i_ce, i_self_test_done, i_int_fail_set, i_ext_fail_set,
         i_fatal_error, i_restart, drive_reset, safe_reset} = 9'h080;
        drive(32'h0, 32'h0);
        step(20);
        cmp_word(o_main_status, safety_status_pkg::MAIN_STATUS_RST);
        cmp_word(o_input_status, safety_status_pkg::INPUT_STATUS_RST);
        cmp_pin({o_led}, 3'h0);
        i_rstn = 1'b1;
        i_self_test_warn = 1'b1;
        step(5);
        check_all();
        i_self_test_done = 1'b1;
        step(1);
        {i_self_test_done, i_self_test_warn} = 2'h0;
        st_m = 1;
        step(3);
        check_all();
        repeat (300) begin
            r = rnd();
            drive((r[31:30] == 2'h0) ? 32'h0 : r, rnd());
            step(1);
            check_all();
        end
        // clock enable low: main word holds while the inputs move
        r = exp_main();
        i_ce = 1'b0;
        drive(rnd(), rnd());
        step(3);
        cmp_word(o_main_status, r);
        i_ce = 1'b1;
        step(1);
        check_all();
        // external failure: wrong source ignored, safe reset clears
        drive(32'h0, 32'h0600_0000);
        r = rnd();
        i_error_code = r[7:0] | 8'h01;
        i_ext_fail_set = 1'b1;
        step(1);
        i_ext_fail_set = 1'b0;
        {ext_m, err_m} = {32'h1, i_error_code};
        step(3);
        check_all();
        cmp_pin(3'(o_cyclic_run), 3'h1);
        drive_reset = 1'b1;
        step(1);
        drive_reset = 1'b0;
        step(3);
        check_all();
        safe_reset = 1'b1;
        step(1);
        safe_reset = 1'b0;
        {ext_m, err_m} = '0;
        step(3);
        check_all();
        // internal failure survives a reset, cleared by restart
        i_error_code = r[15:8] | 8'h01;
        i_int_fail_set = 1'b1;
        step(1);
        i_int_fail_set = 1'b0;
        safe_reset = 1'b1;
        step(1);
        safe_reset = 1'b0;
        step(3);
        cmp_word(o_main_status & 32'hff00_0800, {i_error_code, 24'h800});
        i_restart = 1'b1;
        step(1);
        i_restart = 1'b0;
        st_m = 0;
        step(3);
        check_all();
        i_self_test_done = 1'b1;
        step(1);
        i_self_test_done = 1'b0;
        st_m = 1;
        // fatal error freezes the last active function
        i_func_active = 5'h01;
        step(3);
        i_fatal_error = 1'b1;
        step(1);
        i_fatal_error = 1'b0;
        i_func_active = 5'h1e;
        i_ext_fail_set = 1'b1;
        step(1);
        i_ext_fail_set = 1'b0;
        step(3);
        cmp_word(o_main_status & 32'h407d, 32'h4);
        cmp_pin(o_led, 3'h4);
        cmp_pin({1'b0, o_cyclic_run, o_safe_output}, 3'h0);
        i_restart = 1'b1;
        step(1);
        i_restart = 1'b0;
        st_m = 0;
        step(3);
        check_all();
        give_verdict();
    end
endmodule : safety_option_status_report_tb_top
